// ---- verilog/tbs_pkg.sv ----
// Constants shared by the two-word burst SRAM port.
package tbs_pkg;
  localparam int TBS_WORD_W = 18;
  localparam int TBS_LANE0_HI = 8;
  localparam int TBS_LANE1_LO = 9;
  localparam int TBS_IMP_PERIOD = 1024;
  localparam logic [9:0] TBS_IMP_LAST = 10'(TBS_IMP_PERIOD - 1);
  localparam logic [10:0] TBS_LOCK_CYCLES = 11'h400;
  localparam int TBS_CLK_NS = 4;
  localparam int TBS_STALL_NS = 30;
  localparam logic [3:0] TBS_STALL_CYC =
    4'((TBS_STALL_NS + TBS_CLK_NS - 1) / TBS_CLK_NS);
  localparam logic [7:0] TBS_CTRL_OFF = 8'h00;
  localparam logic [7:0] TBS_STATUS_OFF = 8'h04;
  localparam logic [7:0] TBS_IMPCNT_OFF = 8'h08;
  localparam logic TBS_CTRL_RST = 1'h0;
  localparam int TBS_CTRL_DLLRST_BIT = 0;
  localparam int TBS_ST_SINGLE_BIT = 0;
  localparam int TBS_ST_LOCKED_BIT = 1;
  localparam int TBS_ST_QOE_BIT = 2;
  localparam int TBS_ST_POSTED_BIT = 3;
  localparam int TBS_ST_STRAP_BIT = 4;
endpackage : tbs_pkg

// ---- verilog/tbs_port.sv ----
// Device side of a two-word burst double-data-rate SRAM port.
// Overview of operation
// R01 - Accesses start and controls sample only on positive input clock rise.
// R02 - Load low, select high at input clock rise starts a read.
// R03 - Bursts are two 18-bit words; address LSB toggles for word two.
// R04 - First read word on negative output clock, second on next positive.
// R05 - Controller never aborts a read burst; reads may issue every cycle.
// R06 - After pending reads finish, bus floats after next positive output rise.
// R07 - Load low, select low at input clock rise starts a write.
// R08 - First write word is taken on the following input clock rise.
// R09 - Second write word is taken on negative input clock rise, then stored.
// R10 - With writes deselected, finish pending writes then ignore inputs.
// R11 - Lane enables are sampled separately with each write word.
// R12 - A byte with its lane enable off keeps its stored value.
// R13 - Both output clocks high at power on selects single-clock mode.
// R14 - Controller inserts an idle cycle between a read and a write.
// R15 - A write followed by reads is held and committed on next write.
// R16 - Reads of a held write address return held data, not the array.
// R17 - Depth expansion uses one load per bank, other controls shared.
// R18 - Output impedance is re-adjusted every 1024 input clock cycles.
// R19 - Two free-running echo strobes follow output clocks, or input clocks.
// R20 - With loop enabled, lock comes 1024 cycles after a stable clock.
// R21 - Input clock stalled for 30 ns or more resets the delay loop.
// R22 - Loop-disable pin low keeps the delay loop off.
// R23 - At power up the port is deselected with outputs floating.
// R24 - Lane zero covers bits 8 to 0, lane one bits 17 to 9.
// R25 - Load high starts nothing and lets the read bus go idle.
`timescale 1ns/1ps
module tbs_port
  import tbs_pkg::*;
#(
  parameter int ADDR_W = 21
) (
  // APB clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB register access.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Input and output clock pairs.
  input wire logic k,
  input wire logic k_n,
  input wire logic c,
  input wire logic c_n,
  // Command, address and lane enables.
  input wire logic load_n,
  input wire logic read_sel,
  input wire logic [1:0] byte_lane_enable_n,
  input wire logic [ADDR_W-1:0] addr,
  // Write data pins.
  input wire logic [TBS_WORD_W-1:0] d,
  // Read data pins.
  output logic [TBS_WORD_W-1:0] q,
  output logic q_oe,
  // Echo strobes.
  output logic echo_strobe,
  output logic echo_strobe_n,
  output logic echo_oe,
  // Delay loop and impedance control.
  input wire logic loop_disable_n,
  output logic dll_locked,
  output logic imp_update
);

  localparam int W = TBS_WORD_W;

  typedef struct packed {
    logic k;
    logic k_n;
    logic c;
    logic c_n;
    logic load_n;
    logic read_sel;
    logic [1:0] ble_n;
    logic loop_dis_n;
    logic [ADDR_W-1:0] addr;
    logic [W-1:0] d;
  } tbs_pins_t;

  typedef struct packed {
    tbs_pins_t s1;
    tbs_pins_t s2;
    logic kp;
    logic knp;
    logic cp;
    logic cnp;
    logic [1:0] strap_cnt;
    logic single_clk;
    logic r_pend;
    logic [ADDR_W-1:0] r_addr;
    logic nxt_v;
    logic [W-1:0] nxt_w0;
    logic [W-1:0] nxt_w1;
    logic sec_v;
    logic [W-1:0] sec_w;
    logic [W-1:0] q;
    logic q_oe;
    logic w_start;
    logic [ADDR_W-1:0] w_addr;
    logic w_two;
    logic [ADDR_W-1:0] wd_addr;
    logic [W-1:0] w_d0;
    logic [1:0] w_m0;
    logic h_v;
    logic [ADDR_W-1:0] h_addr;
    logic [W-1:0] h_d0;
    logic [W-1:0] h_d1;
    logic [1:0] h_m0;
    logic [1:0] h_m1;
    logic echo_p;
    logic echo_n;
    logic echo_oe;
    logic [10:0] lock_cnt;
    logic dll_locked;
    logic [3:0] stall;
    logic [9:0] imp_cnt;
    logic imp_update;
    logic [15:0] imp_total;
    logic ctrl_dll_rst;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } tbs_state_t;

  tbs_state_t state_reg;
  tbs_state_t state_next;
  tbs_pins_t pins_in;
  logic [W-1:0] mem [0:(1<<ADDR_W)-1];
  logic commit;

  function automatic logic [W-1:0] tbs_merge(input logic [W-1:0] old_w,
                                             input logic [W-1:0] new_w,
                                             input logic [1:0] en);
    logic [W-1:0] res;
    res = old_w;
    for (int i = 0; i < W; i++) begin
      if ((i <= TBS_LANE0_HI) ? en[0] : en[1]) begin // see R24
        res[i] = new_w[i]; // see R11
      end
    end
    return res;
  endfunction : tbs_merge

  function automatic logic [ADDR_W-1:0] tbs_second(
      input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:1], ~a[0]}; // see R03
  endfunction : tbs_second

  // Read data comes from the posted write when its address matches.
  function automatic logic [W-1:0] tbs_fetch(input logic [ADDR_W-1:0] a,
                                             input logic [W-1:0] arr,
                                             input tbs_state_t s);
    logic [W-1:0] res;
    res = arr;
    if (s.h_v && a == s.h_addr) begin
      res = tbs_merge(arr, s.h_d0, s.h_m0); // see R16
    end else if (s.h_v && a == tbs_second(s.h_addr)) begin
      res = tbs_merge(arr, s.h_d1, s.h_m1); // see R16
    end
    return res;
  endfunction : tbs_fetch

  assign pins_in = '{k: k, k_n: k_n, c: c, c_n: c_n, load_n: load_n,
                     read_sel: read_sel, ble_n: byte_lane_enable_n,
                     loop_dis_n: loop_disable_n, addr: addr, d: d};

  always_comb begin
    tbs_state_t r;
    logic kr;
    logic knr;
    logic op;
    logic on;
    logic dll_en;
    logic [ADDR_W-1:0] ra1;
    r = state_reg;
    state_next = r;
    commit = 1'b0;
    // Only the second stage is looked at; the first just settles pins.
    state_next.s1 = pins_in;
    state_next.s2 = r.s1;
    state_next.kp = r.s2.k;
    state_next.knp = r.s2.k_n;
    state_next.cp = r.s2.c;
    state_next.cnp = r.s2.c_n;
    kr = r.s2.k & ~r.kp;
    knr = r.s2.k_n & ~r.knp;
    ra1 = tbs_second(r.r_addr);
    // The strap is caught once the synchronisers hold real pin levels.
    if (r.strap_cnt != 2'h3) begin
      state_next.strap_cnt = r.strap_cnt + 2'h1;
      if (r.strap_cnt == 2'h2) begin
        state_next.single_clk = r.s2.c & r.s2.c_n; // see R13
      end
    end
    op = r.single_clk ? kr : (r.s2.c & ~r.cp);
    on = r.single_clk ? knr : (r.s2.c_n & ~r.cnp);
    if (r.strap_cnt != 2'h3) begin
      op = 1'b0;
      on = 1'b0;
    end
    // Output side: word one on negative edge, word two on positive.
    if (on && r.nxt_v) begin
      state_next.q = r.nxt_w0; // see R04
      state_next.q_oe = 1'b1;
      state_next.sec_v = 1'b1;
      state_next.sec_w = r.nxt_w1;
      state_next.nxt_v = 1'b0;
    end
    if (op) begin
      if (r.sec_v) begin
        state_next.q = r.sec_w; // see R04
        state_next.sec_v = 1'b0;
      end else begin
        state_next.q_oe = 1'b0; // see R06
      end
    end
    // Input side: all commands are taken on the positive input edge.
    if (kr) begin // see R01
      if (r.r_pend) begin
        state_next.nxt_v = 1'b1;
        state_next.nxt_w0 = tbs_fetch(r.r_addr, mem[r.r_addr], r);
        state_next.nxt_w1 = tbs_fetch(ra1, mem[ra1], r); // see R03
      end
      state_next.r_pend = ~r.s2.load_n & r.s2.read_sel; // see R02
      if (!r.s2.load_n && r.s2.read_sel) begin
        state_next.r_addr = r.s2.addr; // see R02
      end
      if (r.w_start) begin
        state_next.w_two = 1'b1;
        state_next.wd_addr = r.w_addr;
        state_next.w_d0 = r.s2.d; // see R08
        state_next.w_m0 = ~r.s2.ble_n; // see R11
        commit = r.h_v; // see R15
        state_next.h_v = 1'b0;
      end
      // With load high nothing new starts and select is ignored.
      state_next.w_start = ~r.s2.load_n & ~r.s2.read_sel; // see R07, R25
      if (!r.s2.load_n && !r.s2.read_sel) begin
        state_next.w_addr = r.s2.addr; // see R07
      end
    end
    // The completed write waits as a posted write for the next write.
    if (knr && r.w_two) begin
      state_next.w_two = 1'b0;
      state_next.h_v = 1'b1; // see R09, R10
      state_next.h_addr = r.wd_addr;
      state_next.h_d0 = r.w_d0;
      state_next.h_m0 = r.w_m0;
      state_next.h_d1 = r.s2.d; // see R09
      state_next.h_m1 = ~r.s2.ble_n; // see R11
    end
    // Echo strobes run free once the strap is known.
    if (r.strap_cnt == 2'h3) begin
      state_next.echo_oe = 1'b1; // see R23
      state_next.echo_p = r.single_clk ? r.s2.k : r.s2.c; // see R19
      state_next.echo_n = r.single_clk ? r.s2.k_n : r.s2.c_n; // see R19
    end
    // Delay loop model: a stalled clock or a low disable pin unlocks it.
    if (kr || knr) begin
      state_next.stall = 4'h0;
    end else if (r.stall != TBS_STALL_CYC) begin
      state_next.stall = r.stall + 4'h1;
    end
    dll_en = r.s2.loop_dis_n & ~r.ctrl_dll_rst; // see R22
    if (!dll_en || r.stall == TBS_STALL_CYC) begin
      state_next.lock_cnt = 11'h000; // see R21, R22
    end else if (kr && r.lock_cnt != TBS_LOCK_CYCLES) begin
      state_next.lock_cnt = r.lock_cnt + 11'h001; // see R20
    end
    state_next.dll_locked = (state_next.lock_cnt == TBS_LOCK_CYCLES);
    // Impedance is re-trimmed on a fixed count of input clock cycles.
    state_next.imp_update = 1'b0;
    if (kr) begin
      state_next.imp_cnt = r.imp_cnt + 10'h001;
      if (r.imp_cnt == TBS_IMP_LAST) begin
        state_next.imp_update = 1'b1; // see R18
        state_next.imp_total = r.imp_total + 16'h0001;
      end
    end
    // APB slave: every access takes one extra wait cycle.
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    if (psel && penable && !r.pready) begin
      state_next.pready = 1'b1;
      state_next.prdata = 32'h0000_0000;
      if (paddr[31:8] != 24'h00_0000) begin
        state_next.pslverr = 1'b1;
      end else begin
        unique case (paddr[7:0])
          TBS_CTRL_OFF: begin
            if (pwrite) begin
              state_next.ctrl_dll_rst = pwdata[TBS_CTRL_DLLRST_BIT];
            end
            state_next.prdata[TBS_CTRL_DLLRST_BIT] = r.ctrl_dll_rst;
          end
          TBS_STATUS_OFF: begin
            state_next.prdata[TBS_ST_SINGLE_BIT] = r.single_clk;
            state_next.prdata[TBS_ST_LOCKED_BIT] = r.dll_locked;
            state_next.prdata[TBS_ST_QOE_BIT] = r.q_oe;
            state_next.prdata[TBS_ST_POSTED_BIT] = r.h_v;
            state_next.prdata[TBS_ST_STRAP_BIT] = (r.strap_cnt == 2'h3);
          end
          TBS_IMPCNT_OFF: begin
            state_next.prdata[15:0] = r.imp_total;
          end
          default: begin
            state_next.pslverr = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0; // see R23
      state_reg.ctrl_dll_rst <= TBS_CTRL_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // The array has no reset; a posted write lands lane by lane.
  always_ff @(posedge pclk) begin
    if (commit) begin
      mem[state_reg.h_addr] <= tbs_merge(mem[state_reg.h_addr],
                                         state_reg.h_d0,
                                         state_reg.h_m0); // see R12
      mem[tbs_second(state_reg.h_addr)] <=
        tbs_merge(mem[tbs_second(state_reg.h_addr)], state_reg.h_d1,
                  state_reg.h_m1); // see R12
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign q = state_reg.q;
  assign q_oe = state_reg.q_oe;
  assign echo_strobe = state_reg.echo_p;
  assign echo_strobe_n = state_reg.echo_n;
  assign echo_oe = state_reg.echo_oe;
  assign dll_locked = state_reg.dll_locked;
  assign imp_update = state_reg.imp_update;

endmodule : tbs_port

// ---- dv/tbs_ctl_model.sv ----
// Controller model driving clocks, commands and write data into the port.
`timescale 1ns/1ps
module tbs_ctl_model
  import tbs_pkg::*;
(
  // Bench side.
  input wire logic pclk,
  input wire logic strap,
  // Port pins.
  output logic k,
  output logic k_n,
  output logic c,
  output logic c_n,
  output logic load_n,
  output logic read_sel,
  output logic [1:0] byte_lane_enable_n,
  output logic [7:0] addr,
  output logic [TBS_WORD_W-1:0] d
);
  logic [2:0] cnt = 3'h0;
  logic run = 1'b1;
  logic pend = 1'b0;
  logic [39:0] pw;
  // The pair is cut from pclk so every pin moves just after a pclk edge.
  always @(posedge pclk) if (run) cnt <= cnt + 3'h1;
  assign k = ~cnt[2];
  assign k_n = cnt[2];
  assign c = strap | k;
  assign c_n = strap | k_n;
  initial {load_n, read_sel, byte_lane_enable_n, addr, d} = 30'h2c000000;
  // One k cycle; released lines flip so stale values never look valid.
  task automatic slot(input logic ld, input logic rs,
                      input logic [7:0] a, input logic [39:0] wd);
    @(posedge pclk iff cnt == 3'h6);
    load_n <= ld;
    read_sel <= rs;
    addr <= ld ? ~addr : a;
    {d, byte_lane_enable_n} <= pend ? pw[19:0] : {~d, 2'h3};
    @(posedge pclk iff cnt == 3'h2);
    load_n <= 1'b1;
    read_sel <= ~rs;
    addr <= ~a;
    {d, byte_lane_enable_n} <= pend ? pw[39:20] : {~d, 2'h3};
    pend <= !ld && !rs;
    pw <= wd;
  endtask : slot
endmodule : tbs_ctl_model

// ---- dv/tbs_port_sva.sv ----
// Concurrent checks on the ports of the burst SRAM port.
`timescale 1ns/1ps
module tbs_port_sva (
  // Clock, reset and register bus.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Pins.
  input wire logic k,
  input wire logic k_n,
  input wire logic q_oe,
  input wire logic echo_oe,
  input wire logic loop_disable_n,
  input wire logic dll_locked,
  input wire logic imp_update
);
  logic [1:0] kk_reg;
  logic [4:0] still_reg;
  logic [13:0] unl_reg;
  wire mapped = paddr == 32'h0 || paddr == 32'h4 || paddr == 32'h8;
  // Both counters saturate so that long runs never wrap into a false pass.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {kk_reg, still_reg, unl_reg} <= 21'h0;
    end else begin
      kk_reg <= {k, k_n};
      still_reg <= ({k, k_n} != kk_reg) ? 5'h0 :
        still_reg + {4'h0, ~&still_reg};
      unl_reg <= dll_locked ? 14'h0 : unl_reg + {13'h0, ~&unl_reg};
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_apb_answer: assert property (s_access |=> s_answer)
    else $error("bus access not answered after one wait");
  a_err_addr: assert property (pready && !mapped |-> pslverr && !prdata)
    else $error("unmapped access without error");
  a_reset_float: assert property (
    disable iff (1'b0) !presetn |-> !q_oe && !echo_oe)
    else $error("outputs driven during reset");
  a_echo_steady: assert property (echo_oe |=> echo_oe)
    else $error("echo strobes stopped");
  a_imp_spaced: assert property (imp_update |=> !imp_update [*8])
    else $error("impedance updates too close");
  a_stall_unlock: assert property (still_reg >= 5'h0e |-> !dll_locked)
    else $error("loop stayed locked through a stall");
  a_off_unlock: assert property (!loop_disable_n [*4] |=> !dll_locked)
    else $error("loop locked while disabled");
  a_lock_late: assert property ($rose(dll_locked) |-> unl_reg >= 14'h1f00)
    else $error("loop locked too early");
endmodule : tbs_port_sva

bind tbs_port tbs_port_sva sva_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .k(k), .k_n(k_n), .q_oe(q_oe),
  .echo_oe(echo_oe), .loop_disable_n(loop_disable_n),
  .dll_locked(dll_locked), .imp_update(imp_update));

// ---- dv/tb_top.sv ----
// Bench for the burst SRAM port: register bus, pin traffic and delay loop.
`timescale 1ns/1ps
module tb_top;
  import tbs_pkg::*;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, loop_disable_n, strap, er;
  logic pready, pslverr, q_oe, echo_strobe, echo_strobe_n, echo_oe;
  logic dll_locked, imp_update, k, k_n, c, c_n, load_n, read_sel;
  logic [31:0] paddr, pwdata, prdata, rv;
  logic [1:0] byte_lane_enable_n;
  logic [7:0] addr, a;
  logic [17:0] d, q;
  logic [17:0] mem [256];
  int fails = 0, n_compared = 0, seed, kcnt, i, n;
  tbs_port #(.ADDR_W(8)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .k(k), .k_n(k_n), .c(c), .c_n(c_n), .load_n(load_n),
    .read_sel(read_sel), .byte_lane_enable_n(byte_lane_enable_n),
    .addr(addr), .d(d), .q(q), .q_oe(q_oe), .echo_strobe(echo_strobe),
    .echo_strobe_n(echo_strobe_n), .echo_oe(echo_oe),
    .loop_disable_n(loop_disable_n), .dll_locked(dll_locked),
    .imp_update(imp_update));
  tbs_ctl_model ctl_u (.pclk(pclk), .strap(strap), .k(k), .k_n(k_n),
    .c(c), .c_n(c_n), .load_n(load_n), .read_sel(read_sel), .addr(addr),
    .d(d), .byte_lane_enable_n(byte_lane_enable_n));
  initial forever #2 pclk = ~pclk;
  always @(posedge k) kcnt <= presetn ? kcnt + 1 : 0;
  task automatic tally_and_finish();
    if (fails == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (100000) @(posedge pclk);
    fails++;
    tally_and_finish();
  end
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(logic w, logic [31:0] ad, logic [31:0] wd);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, ad, wd};
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge pclk);
    {rv, er} = {prdata, pslverr};
    {psel, penable} <= 2'h0;
    if (n == 20) tally_and_finish();
  endtask : apb
  function automatic logic [17:0] mrg(logic [17:0] o, w, logic [1:0] be);
    return {be[1] ? o[17:9] : w[17:9], be[0] ? o[8:0] : w[8:0]};
  endfunction : mrg
  task automatic wr(logic [7:0] wa, logic full);
    logic [39:0] v;
    v = 40'({$random(seed), $random(seed)}) & (full ? 40'hffffcffffc : '1);
    mem[wa] = mrg(mem[wa], v[19:2], v[1:0]);
    mem[wa ^ 8'h1] = mrg(mem[wa ^ 8'h1], v[39:22], v[21:20]);
    ctl_u.slot(1'b0, 1'b0, wa, v);
  endtask : wr
  task automatic rd(logic [7:0] ra);
    logic [17:0] e0, e1;
    {e0, e1} = {mem[ra], mem[ra ^ 8'h1]};
    ctl_u.slot(1'b0, 1'b1, ra, 40'h0);
    fork
      begin
        repeat (13) @(posedge pclk);
        @(negedge pclk);
        chk("first word", {q_oe, q}, {1'b1, e0});
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        chk("second word", {q_oe, q}, {1'b1, e1});
      end
    join_none
  endtask : rd
  task automatic lockw();
    for (n = 0; n < 9000 && dll_locked !== 1'b1; n++) @(posedge pclk);
    chk("lock", dll_locked, 1'b1);
    if (n == 9000) tally_and_finish();
  endtask : lockw
  initial begin
    seed = 32'h0ce34149;
    {presetn, psel, penable, pwrite, strap, loop_disable_n} = 6'h1;
    {paddr, pwdata} = 64'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b1, 32'h4, 32'hffffffff);
    apb(1'b0, 32'h0, 32'h0);
    chk("control", rv, 32'h0);
    apb(1'b0, 32'h4, 32'h0);
    chk("status", rv & 32'h13, 32'h10);
    apb(1'b0, 32'h10c, 32'h0);
    chk("unmapped", {er, rv[30:0]}, 32'h80000000);
    for (i = 0; i < 16; i += 2) wr(8'(i), 1'b1);
    for (i = 0; i < 13; i++) begin
      ctl_u.slot(1'b1, 1'b0, 8'h0, 40'h0);
      a = 8'($random(seed)) & 8'h0f;
      if (i < 12) wr(a, 1'b0);
      if (i < 12) rd(a);
      if (i < 12) rd(8'($random(seed)) & 8'h0f);
    end
    repeat (40) @(posedge pclk);
    chk("read bus idle", q_oe, 1'b0);
    lockw();
    apb(1'b0, 32'h8, 32'h0);
    chk("impedance count", rv, kcnt / 1024);
    ctl_u.run <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("stall", dll_locked, 1'b0);
    ctl_u.run <= 1'b1;
    lockw();
    apb(1'b1, 32'h0, 32'h1);
    apb(1'b0, 32'h4, 32'h0);
    chk("forced unlock", rv[1], 1'b0);
    loop_disable_n <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("disabled", dll_locked, 1'b0);
    chk("echo", {echo_oe, echo_strobe ^ echo_strobe_n}, 2'h3);
    // Reset drops a held write; reset comes before this spare-word write can commit the last one.
    wr(8'h20, 1'b1);
    {presetn, strap} <= 2'h1;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(1'b0, 32'h4, 32'h0);
    chk("single clock", rv & 32'h11, 32'h11);
    wr(8'h5, 1'b0);
    rd(8'h4);
    repeat (40) @(posedge pclk);
    tally_and_finish();
  end
endmodule : tb_top
